// ===== daa_irq_mask_watchdog_ctrl.v
// interrupt pin control, source masking, access watchdog and path enables
// assumes an apb master on i_clk and detector levels from analog circuits,
// and software that clears event flags by writing 0 to them
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`include "daa_irq_map.vh"

module daa_irq_mask_watchdog_ctrl #(
   parameter [`WDT_W-1:0] WDT_CYCLES = `WDT_TIME_MS * `CLK_KHZ
) (
   // clock and reset
   input  wire                 i_clk,
   input  wire                 i_rst,
   // apb slave
   input  wire                 i_psel,
   input  wire                 i_penable,
   input  wire                 i_pwrite,
   input  wire [`ADDR_W-1:0]   i_paddr,
   input  wire [`DATA_W-1:0]   i_pwdata,
   output reg  [`DATA_W-1:0]   o_prdata,
   output wire                 o_pready,
   output wire                 o_pslverr,
   // detector inputs from the line side
   input  wire                 i_ring_active,
   input  wire                 i_rx_overload,
   input  wire                 i_link_unlocked,
   input  wire                 i_metering_tone,
   input  wire                 i_supply_dropout,
   input  wire [`REG_W-1:0]    i_loop_current_level,
   input  wire                 i_line_voltage_top,
   // line interface controls
   output reg                  o_irq,
   output reg                  o_line_seize,
   output reg                  o_hybrid_connect,
   output reg                  o_rx_path_on
);

   //*********************************************************************
   // decode
   //*********************************************************************
   function mapped;
      input [`ADDR_W-1:0] a;
      begin
         // a misaligned address is never mapped
         mapped = (a[1:0] == 2'h0) &&
                  (({2'h0, a[`ADDR_W-1:2]} == `IDX_CTRL) ||
                   ({2'h0, a[`ADDR_W-1:2]} == `IDX_MASK) ||
                   ({2'h0, a[`ADDR_W-1:2]} == `IDX_FLAGS) ||
                   ({2'h0, a[`ADDR_W-1:2]} == `IDX_LINE));
      end
   endfunction

   function hit;
      input [`ADDR_W-1:0] a;
      input [`ADDR_W-1:0] idx;
      begin
         hit = (a[1:0] == 2'h0) && (a[`ADDR_W-1:2] == idx[`ADDR_W-3:0]);
      end
   endfunction

   wire                access = i_psel & i_penable;
   wire                setup  = i_psel & ~i_penable;
   wire                wr     = access & i_pwrite & mapped(i_paddr);
   wire [`REG_W-1:0]   wdat   = i_pwdata[`REG_W-1:0];

   // the slave answers in the first access cycle, no wait states
   assign o_pready  = 1'b1;
   // unmapped offsets answer with an error and write no register; they still restart the watchdog window
   assign o_pslverr = access & ~mapped(i_paddr);

   //*********************************************************************
   // write strobes
   //*********************************************************************
   // one strobe per register, taken at the access edge
   wire                ctrl_wr = wr & hit(i_paddr, `IDX_CTRL);
   wire                mask_wr = wr & hit(i_paddr, `IDX_MASK);
   wire                line_wr = wr & hit(i_paddr, `IDX_LINE);

   //*********************************************************************
   // input synchronisers
   //*********************************************************************
   // levels only; the loop bus may skew one cycle across bits, which at
   // worst delays the all-ones event by a cycle
   // a two-cycle pulse is the shortest event sure to be seen
   localparam SYNC_W = `N_BIT_SRC + `REG_W;

   wire [SYNC_W-1:0] sync_in = {i_ring_active, i_rx_overload,
                                i_link_unlocked, i_metering_tone,
                                i_supply_dropout, i_line_voltage_top,
                                i_loop_current_level};
   reg  [SYNC_W-1:0] sync1_r;
   reg  [SYNC_W-1:0] sync2_r;

   // first stage, read by nothing but the second stage
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sync1_r <= {SYNC_W{1'b0}};
      end else begin
         sync1_r <= sync_in;
      end
   end

   // second stage, the only copy the logic below may use
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sync2_r <= {SYNC_W{1'b0}};
      end else begin
         sync2_r <= sync1_r;
      end
   end

   wire              ring_s    = sync2_r[SYNC_W-1];
   wire              ovl_s     = sync2_r[SYNC_W-2];
   wire              unlock_s  = sync2_r[SYNC_W-3];
   wire              meter_s   = sync2_r[SYNC_W-4];
   wire              drop_s    = sync2_r[SYNC_W-5];
   wire              lvtop_s   = sync2_r[SYNC_W-6];
   wire [`REG_W-1:0] lcs_s     = sync2_r[`REG_W-1:0];

   // previous samples for edge detection
   reg ring_d_r;
   reg lvtop_d_r;
   reg edge_prime_r;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ring_d_r     <= 1'b0;
         lvtop_d_r    <= 1'b0;
         edge_prime_r <= 1'b0;
      end else begin
         ring_d_r     <= ring_s;
         lvtop_d_r    <= lvtop_s;
         edge_prime_r <= 1'b1;
      end
   end

   // only the first cycle after reset is masked, while the second stage still reads zero; an input high across reset counts as an edge
   wire ring_rise = edge_prime_r & ring_s & ~ring_d_r;
   wire ring_fall = edge_prime_r & ~ring_s & ring_d_r;
   wire pol_flip  = edge_prime_r & (lvtop_s ^ lvtop_d_r);
   // loop bus at full scale is a level event
   wire loop_full = &lcs_s;

   //*********************************************************************
   // control register
   //*********************************************************************
   reg  [`REG_W-1:0] ctrl_r;
   reg  [`REG_W-1:0] ctrl_nxt;

   always @* begin
      ctrl_nxt = ctrl_r;
      if (ctrl_wr) begin
         // reserved bits are dropped on write and read back as zero
         ctrl_nxt = wdat & `CTRL_WR_MASK;
         // sticky enable, only reset clears it
         ctrl_nxt[`B_WDT_ON] = ctrl_r[`B_WDT_ON] | wdat[`B_WDT_ON];
      end
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_r <= `CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   wire irq_pin_on  = ctrl_r[`B_IRQ_PIN_ON];
   wire irq_level   = ctrl_r[`B_IRQ_LEVEL];
   wire wdt_on      = ctrl_r[`B_WDT_ON];
   wire ring_dual   = ctrl_r[`B_RING_EDGE];

   //*********************************************************************
   // mask register
   //*********************************************************************
   reg  [`REG_W-1:0] mask_r;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         mask_r <= `MASK_RESET;
      end else if (mask_wr) begin
         // reserved bit 1 cannot be set, so it never gates a flag
         mask_r <= wdat & `SRC_MASK;
      end
   end

   //*********************************************************************
   // watchdog
   //*********************************************************************
   reg  [`WDT_W-1:0] wdt_cnt_r;
   reg  [`WDT_W-1:0] wdt_cnt_nxt;
   reg               wdt_fire;
   // held at zero while disabled, so enabling starts a full window
   wire              wdt_hold = ~wdt_on | access;
   // last idle cycle of the window
   wire              wdt_due  = (wdt_cnt_r >= WDT_CYCLES - 1'b1);

   always @* begin
      wdt_cnt_nxt = wdt_cnt_r;
      wdt_fire    = 1'b0;
      if (wdt_hold) begin
         // any completed access, writes included, restarts the window
         wdt_cnt_nxt = {`WDT_W{1'b0}};
      end else if (wdt_due) begin
         wdt_cnt_nxt = {`WDT_W{1'b0}};
         wdt_fire    = 1'b1;
      end else begin
         wdt_cnt_nxt = wdt_cnt_r + 1'b1;
      end
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wdt_cnt_r <= {`WDT_W{1'b0}};
      end else begin
         wdt_cnt_r <= wdt_cnt_nxt;
      end
   end

   //*********************************************************************
   // line seize register
   //*********************************************************************
   reg  [`REG_W-1:0] line_r;
   reg  [`REG_W-1:0] line_nxt;

   always @* begin
      line_nxt = line_r;
      if (wdt_fire) begin
         line_nxt[`B_LINE_SEIZE] = 1'b0;
      end
      // only bit 0 is writable; the rest keep their reset zero
      if (line_wr) begin
         // a write also cancels expiry, so software wins here
         line_nxt[`B_LINE_SEIZE] = wdat[`B_LINE_SEIZE];
      end
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         line_r <= `LINE_RESET;
      end else begin
         line_r <= line_nxt;
      end
   end

   //*********************************************************************
   // event flags
   //*********************************************************************
   reg  [`REG_W-1:0] flags_r;
   reg  [`REG_W-1:0] flags_nxt;
   reg  [`REG_W-1:0] set_ev;
   wire              flag_wr = wr && hit(i_paddr, `IDX_FLAGS);
   // ring end counts only in dual mode with the start flag cleared,
   // so an unserviced start hides the end
   wire              ring_start_ev = ring_rise;
   wire              ring_end_ev   = ring_dual & ring_fall &
                                     ~flags_r[`B_RING];

   always @* begin
      set_ev = {`REG_W{1'b0}};
      set_ev[`B_RING] = ring_start_ev | ring_end_ev;
      // level sources re-set every cycle they stay high, so a clear
      // only sticks once the cause has gone
      set_ev[`B_RX_OVL]    = ovl_s;
      set_ev[`B_LINK_LOCK] = unlock_s;
      set_ev[`B_METER]     = meter_s;
      set_ev[`B_DROPOUT]   = drop_s;
      set_ev[`B_LOOP_FULL] = loop_full;
      set_ev[`B_POL_FLIP]  = pol_flip;
   end

   always @* begin
      flags_nxt = flags_r;
      if (flag_wr) begin
         // writing 0 clears, writing 1 leaves the flag alone
         flags_nxt = flags_r & wdat;
      end
      // a new event in the clearing cycle is kept
      flags_nxt = (flags_nxt | set_ev) & `SRC_MASK;
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         flags_r <= `FLAGS_RESET;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   //*********************************************************************
   // interrupt pin and path outputs
   //*********************************************************************
   // per-source gating, reserved bit is zero in the mask
   wire [`REG_W-1:0] gated = flags_r & mask_r;
   wire              pend_src = |gated;
   wire              pend = pend_src & irq_pin_on;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         // rests high, matching the active-low default
         o_irq <= 1'b1;
      end else begin
         o_irq <= irq_level ? pend : ~pend;
      end
   end
   // the pin level above is the OR of pending sources gated by the pin enable bit, inverted while the level bit selects active low

   // path controls lag their bits by one edge, like the pin
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_line_seize     <= 1'b0;
         o_hybrid_connect <= 1'b0;
         o_rx_path_on     <= 1'b0;
      end else begin
         o_line_seize     <= line_r[`B_LINE_SEIZE];
         o_hybrid_connect <= ctrl_r[`B_HYBRID];
         o_rx_path_on     <= ctrl_r[`B_RX_PATH];
      end
   end

   //*********************************************************************
   // read data
   //*********************************************************************
   // unmapped offsets and bits above the byte read as zero
   reg [`REG_W-1:0] rd_mux;

   always @* begin
      rd_mux = {`REG_W{1'b0}};
      if (hit(i_paddr, `IDX_CTRL)) begin
         rd_mux = ctrl_r;
      end else if (hit(i_paddr, `IDX_MASK)) begin
         rd_mux = mask_r;
      end else if (hit(i_paddr, `IDX_FLAGS)) begin
         rd_mux = flags_r;
      end else if (hit(i_paddr, `IDX_LINE)) begin
         rd_mux = line_r;
      end
   end

   // captured in the setup cycle so the access phase sees a flop value;
   // a flag set during the access phase shows on the next read
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_prdata <= {`DATA_W{1'b0}};
      end else if (setup && !i_pwrite) begin
         o_prdata <= {{(`DATA_W-`REG_W){1'b0}}, rd_mux};
      end
   end

endmodule // daa_irq_mask_watchdog_ctrl

// ===== daa_irq_map.vh
// register map, field positions, reset values and timing for the
// line-interface control block; assumes a 100 mhz device clock
`ifndef DAA_IRQ_MAP_VH
`define DAA_IRQ_MAP_VH

// register indices, byte address is four times the index
`define IDX_CTRL       8'h02
`define IDX_MASK       8'h03
`define IDX_FLAGS      8'h04
`define IDX_LINE       8'h05
`define ADDR_W         8
`define DATA_W         32
`define REG_W          8
`define N_BIT_SRC      6

// irq_watchdog_path_ctrl fields
`define B_IRQ_PIN_ON   7
`define B_IRQ_LEVEL    6
`define B_WDT_ON       4
`define B_RING_EDGE    2
`define B_HYBRID       1
`define B_RX_PATH      0
`define CTRL_WR_MASK   8'hd7
`define CTRL_RESET     8'h00

// irq_source_mask_bits and flag fields
`define B_RING         7
`define B_RX_OVL       6
`define B_LINK_LOCK    5
`define B_METER        4
`define B_DROPOUT      3
`define B_LOOP_FULL    2
`define B_POL_FLIP     0
`define SRC_MASK       8'hfd
`define MASK_RESET     8'h00
`define FLAGS_RESET    8'h00

// line register
`define B_LINE_SEIZE   0
`define LINE_RESET     8'h00

// watchdog window
`define WDT_TIME_MS    4000
`define CLK_KHZ        100000
`define WDT_W          29
`endif

// ===== daa_irq_monitor.sv
// port assertions for the interrupt, watchdog and path control block
// assumes byte addresses 0x08 ctrl, 0x0c mask, 0x14 line; short watchdog
`timescale 1ns/1ns
`include "daa_irq_map.vh"
module daa_irq_monitor #(
   parameter [`WDT_W-1:0] WDT_CYCLES = 50
) (
   // clock, reset and bus
   input wire                i_clk,
   input wire                i_rst,
   input wire                i_psel,
   input wire                i_penable,
   input wire                i_pwrite,
   input wire [`ADDR_W-1:0]  i_paddr,
   input wire [`DATA_W-1:0]  i_pwdata,
   input wire [`DATA_W-1:0]  o_prdata,
   // line outputs
   input wire                o_irq,
   input wire                o_line_seize,
   input wire                o_hybrid_connect,
   input wire                o_rx_path_on
);
   // ****************************************
   // shadow registers and idle count
   // ****************************************
   reg  [7:0]  ctrl_r;
   reg  [7:0]  mask_r;
   reg  [31:0] idle_r;
   wire        acc_w = i_psel & i_penable;
   wire        wr_w  = acc_w & i_pwrite;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_r <= 8'h00;
         mask_r <= 8'h00;
         idle_r <= 32'h0;
      end else begin
         // watchdog bit only ever set here, never cleared
         if (wr_w && i_paddr == 8'h08)
            ctrl_r <= (i_pwdata[7:0] & `CTRL_WR_MASK) | (ctrl_r & 8'h10);
         if (wr_w && i_paddr == 8'h0c)
            mask_r <= i_pwdata[7:0] & `SRC_MASK;
         if (acc_w)
            idle_r <= 32'h0;
         else if (ctrl_r[4])
            idle_r <= idle_r + 32'h1;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence line_set_s;
      wr_w && i_paddr == 8'h14 && i_pwdata[0];
   endsequence
   irq_idle_a: assert property (
      !$past(ctrl_r[7]) |-> o_irq == !$past(ctrl_r[6]))
      else $error("irq pin active while disabled");
   irq_masked_a: assert property (
      $past(mask_r) == 8'h00 |-> o_irq == !$past(ctrl_r[6]))
      else $error("irq pin active with all sources masked");
   hybrid_follow_a: assert property (
      o_hybrid_connect == $past(ctrl_r[1]))
      else $error("hybrid output differs from its bit");
   rx_follow_a: assert property (
      o_rx_path_on == $past(ctrl_r[0]))
      else $error("receive enable differs from its bit");
   wdt_sticky_a: assert property (
      acc_w && !i_pwrite && i_paddr == 8'h08 && ctrl_r[4] |-> o_prdata[4])
      else $error("watchdog enable read back clear");
   seize_set_a: assert property (
      line_set_s |-> ##2 o_line_seize)
      else $error("line seize not taken");
   wdt_expire_a: assert property (
      idle_r == WDT_CYCLES + 3 |-> !o_line_seize)
      else $error("watchdog did not release the line");
   wdt_early_a: assert property (
      $fell(o_line_seize) && idle_r > 3 |-> idle_r + 3 >= WDT_CYCLES)
      else $error("line released before watchdog window");
endmodule // daa_irq_monitor

bind daa_irq_mask_watchdog_ctrl daa_irq_monitor #(.WDT_CYCLES(WDT_CYCLES))
   u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_irq(o_irq),
      .o_line_seize(o_line_seize), .o_hybrid_connect(o_hybrid_connect),
      .o_rx_path_on(o_rx_path_on));

// ===== apb_host.sv
// host controller model: apb master reaching the device registers
// assumes a free running clock; waits on pready without a count
`timescale 1ns/1ns
module apb_host (
   // clock and slave answer
   input  wire          i_clk,
   input  wire          i_pready,
   input  wire          i_pslverr,
   input  wire [31:0]   i_prdata,
   // master request
   output reg           o_psel,
   output reg           o_penable,
   output reg           o_pwrite,
   output reg  [7:0]    o_paddr,
   output reg  [31:0]   o_pwdata
);
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 8'h00;
      o_pwdata = 32'h0;
   end
   // request held until pready seen high at an edge
   task xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
             output logic [31:0] q, output logic e);
      @(posedge i_clk);
      o_psel <= 1'b1;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= {24'h0, d};
      @(posedge i_clk);
      o_penable <= 1'b1;
      @(posedge i_clk);
      while (i_pready !== 1'b1) @(posedge i_clk);
      q = i_prdata;
      e = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
   endtask
endmodule // apb_host

// ===== test_daa_irq_mask_watchdog_ctrl.sv
// self-checking bench for the interrupt, watchdog and path control block
// assumes the host model drives the bus; detectors driven here
`timescale 1ns/1ns
`include "daa_irq_map.vh"
module test_daa_irq_mask_watchdog_ctrl;
   localparam [`WDT_W-1:0] WDT = 29'd50;
   logic i_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
   logic [7:0]  i_paddr, i_loop_current_level;
   logic [31:0] i_pwdata, o_prdata;
   logic i_ring_active, i_rx_overload, i_link_unlocked, i_metering_tone;
   logic i_supply_dropout, i_line_voltage_top, o_irq, o_line_seize;
   logic o_hybrid_connect, o_rx_path_on;
   int failures = 0;
   int n_tests = 0;
   int srcs[7] = '{7, 6, 5, 4, 3, 2, 0};
   daa_irq_mask_watchdog_ctrl #(.WDT_CYCLES(WDT)) dut (.i_clk(i_clk),
      .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_ring_active(i_ring_active), .i_rx_overload(i_rx_overload),
      .i_link_unlocked(i_link_unlocked), .i_metering_tone(i_metering_tone),
      .i_supply_dropout(i_supply_dropout),
      .i_loop_current_level(i_loop_current_level),
      .i_line_voltage_top(i_line_voltage_top), .o_irq(o_irq),
      .o_line_seize(o_line_seize), .o_hybrid_connect(o_hybrid_connect),
      .o_rx_path_on(o_rx_path_on));
   apb_host u_host (.i_clk(i_clk), .i_pready(o_pready),
      .i_pslverr(o_pslverr), .i_prdata(o_prdata), .o_psel(i_psel),
      .o_penable(i_penable), .o_pwrite(i_pwrite), .o_paddr(i_paddr),
      .o_pwdata(i_pwdata));
   // ****************************************
   // helpers
   // ****************************************
   task cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         failures++;
         $display("MISMATCH %s exp %h got %h", n, x, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      u_host.xfer(1'b1, a, d, q, e);
   endtask
   task rdc(input string n, input logic [7:0] a, input logic [31:0] x);
      logic [31:0] q;
      logic e;
      u_host.xfer(1'b0, a, 8'h00, q, e);
      chk(n, x, q);
   endtask
   // polarity source counts any change, so a set toggles the bit
   task set_src(input int b, input logic v);
      case (b)
         7: i_ring_active <= v;
         6: i_rx_overload <= v;
         5: i_link_unlocked <= v;
         4: i_metering_tone <= v;
         3: i_supply_dropout <= v;
         2: i_loop_current_level <= v ? 8'hff : 8'hfe;
         default: if (v) i_line_voltage_top <= ~i_line_voltage_top;
      endcase
   endtask
   task test_done;
      if (failures == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_regs;
      logic [31:0] q;
      logic e;
      rdc("ctrl", 8'h08, 32'h0);
      rdc("flags", 8'h10, 32'h0);
      rdc("line", 8'h14, 32'h0);
      wr(8'h0c, 8'hff);
      rdc("mask", 8'h0c, 32'hfd);
      u_host.xfer(1'b0, 8'h40, 8'h00, q, e);
      chk("unmapped", 32'h1, {31'h0, e});
      chk("pready", 32'h1, {31'h0, o_pready});
   endtask
   task t_paths;
      wr(8'h08, 8'h03);
      cyc(3);
      chk("hybrid", 32'h1, {31'h0, o_hybrid_connect});
      chk("rx", 32'h1, {31'h0, o_rx_path_on});
      wr(8'h08, 8'h01);
      cyc(3);
      chk("hybrid", 32'h0, {31'h0, o_hybrid_connect});
      chk("rx", 32'h1, {31'h0, o_rx_path_on});
   endtask
   task t_sources;
      foreach (srcs[k]) begin
         wr(8'h0c, 8'h01 << srcs[k]);
         wr(8'h08, 8'hc0);
         set_src(srcs[k], 1'b1);
         cyc(2);
         set_src(srcs[k], 1'b0);
         cyc(6);
         chk("irq high", 32'h1, {31'h0, o_irq});
         wr(8'h08, 8'h80);
         cyc(3);
         chk("irq low", 32'h0, {31'h0, o_irq});
         wr(8'h08, 8'h40);
         cyc(3);
         chk("irq off", 32'h0, {31'h0, o_irq});
         wr(8'h08, 8'hc0);
         wr(8'h0c, 8'h00);
         cyc(3);
         chk("irq masked", 32'h0, {31'h0, o_irq});
         rdc("flag set", 8'h10, 32'h1 << srcs[k]);
         wr(8'h10, 8'h00);
         rdc("flag clear", 8'h10, 32'h0);
      end
   endtask
   task t_ring;
      wr(8'h0c, 8'h80);
      for (int m = 0; m < 2; m++) begin
         wr(8'h08, {5'h18, m[0], 2'b00});
         set_src(7, 1'b1);
         cyc(6);
         rdc("ring start", 8'h10, 32'h80);
         wr(8'h10, 8'h00);
         set_src(7, 1'b0);
         cyc(6);
         rdc("ring end", 8'h10, m ? 32'h80 : 32'h0);
         wr(8'h10, 8'h00);
      end
   endtask
   task t_wdt;
      wr(8'h14, 8'h01);
      cyc(3);
      chk("seize", 32'h1, {31'h0, o_line_seize});
      wr(8'h08, 8'h10);
      wr(8'h08, 8'h00);
      rdc("wdt sticky", 8'h08, 32'h10);
      cyc(WDT - 15);
      wr(8'h0c, 8'h00);
      cyc(WDT - 15);
      chk("seize kept", 32'h1, {31'h0, o_line_seize});
      cyc(30);
      chk("seize dropped", 32'h0, {31'h0, o_line_seize});
      rdc("line bit", 8'h14, 32'h0);
      wr(8'h14, 8'h01);
      cyc(3);
      chk("seize again", 32'h1, {31'h0, o_line_seize});
   endtask
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // whole run is near 530 cycles; cut off well beyond
   initial begin
      #50000;
      failures++;
      test_done;
   end
   initial begin
      i_rst = 1'b1;
      {i_ring_active, i_rx_overload, i_link_unlocked} = 3'b000;
      {i_metering_tone, i_supply_dropout, i_line_voltage_top} = 3'b000;
      i_loop_current_level = 8'h00;
      cyc(12);
      i_rst <= 1'b0;
      t_regs;
      t_paths;
      t_sources;
      t_ring;
      t_wdt;
      test_done;
   end
endmodule // test_daa_irq_mask_watchdog_ctrl
